// >>> hw/cpms_pkg.sv
// Package with register map, field positions, states and timing constants.
// Operation
// - Low for the least low time, then high for the least high time starts tuning.
// - Request held high at power-on withholds power-on tuning until cycled low-high.
// - Extended control ORs the request pin with control bit 15; both low first.
// - Delay select high gives the long power-on wait, low the short one.
// - Tune-in-progress is high exactly while a tuning sequence runs.
// - Phase select low gives 0 degree data phase, high gives 90 degree phase.
// - Phase select only acts in 1:2 demux mode, nondemux select low.
// - Extended control takes phase from control bit 14, default 0 degrees.
// - Pin control: interleave high samples input I on both channels, else independent.
// - Extended control takes interleaving from control bit 7, default independent.
// - Enable low opens the register port; the phase, interleave and range pins lose effect.
// - Enable high closes the register port and holds registers at defaults.
// - Pin control: range pin low gives low range, high gives high, both channels.
// - Extended control: I range from register 3h, Q range from register Bh.
// - Nondemux select high gives 1:1 output, low 1:2, pin only always.
// - Serial select high keeps the serial output released.
package cpms_pkg;

   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam int unsigned T_TUNE_LOW_NS = 100;
   localparam int unsigned T_TUNE_HIGH_NS = 100;
   localparam int unsigned TUNE_LOW_CYC =
      (T_TUNE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned TUNE_HIGH_CYC =
      (T_TUNE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned POR_SHORT_CYC_DEF = 32768;
   localparam int unsigned POR_LONG_CYC_DEF = 1048576;
   localparam int unsigned TUNE_RUN_CYC_DEF = 65536;

   localparam int unsigned CNT_W = 24;
   localparam logic [CNT_W-1:0] TUNE_LOW_LAST = CNT_W'(TUNE_LOW_CYC - 1);
   localparam logic [CNT_W-1:0] TUNE_HIGH_LAST = CNT_W'(TUNE_HIGH_CYC - 1);
   localparam logic [CNT_W-1:0] STARTUP_LAST = 24'h000003;

   localparam int unsigned AXI_AW = 8;
   localparam logic [7:0] CTRL_IDX = 8'h00;
   localparam logic [7:0] RANGE_I_IDX = 8'h03;
   localparam logic [7:0] RANGE_Q_IDX = 8'h0B;
   localparam logic [7:0] STATUS_IDX = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int unsigned TUNE_BIT = 15;
   localparam int unsigned PHASE_BIT = 14;
   localparam int unsigned ILV_BIT = 7;
   localparam logic [31:0] CTRL_WMASK = 32'h0000C080;
   localparam logic [31:0] CTRL_RST = 32'h00000000;

   localparam int unsigned RANGE_W = 4;
   localparam logic [RANGE_W-1:0] RANGE_MIN = 4'h0;
   localparam logic [RANGE_W-1:0] RANGE_MID = 4'h8;
   localparam logic [RANGE_W-1:0] RANGE_RST = 4'h8;

   localparam int unsigned ST_TIP_POS = 0;
   localparam int unsigned ST_ECM_POS = 1;
   localparam int unsigned ST_PH_POS = 2;
   localparam int unsigned ST_DMX_POS = 3;
   localparam int unsigned ST_ILV_POS = 4;
   localparam int unsigned ST_INH_POS = 5;
   localparam int unsigned ST_RI_POS = 8;
   localparam int unsigned ST_RQ_POS = 12;

   localparam int unsigned PIN_N = 8;
   localparam int unsigned PIN_TUNE = 0;
   localparam int unsigned PIN_DLY = 1;
   localparam int unsigned PIN_PHASE = 2;
   localparam int unsigned PIN_ILV = 3;
   localparam int unsigned PIN_ECE_N = 4;
   localparam int unsigned PIN_RANGE = 5;
   localparam int unsigned PIN_NDM = 6;
   localparam int unsigned PIN_SCS_N = 7;

   typedef enum logic [2:0]
   {
      ST_START    = 3'h0,
      ST_POR_WAIT = 3'h1,
      ST_RUN      = 3'h3,
      ST_READY    = 3'h2,
      ST_INHIBIT  = 3'h6
   } cpms_state_t;

   typedef enum logic [2:0]
   {
      SEL_CTRL   = 3'h0,
      SEL_RANGEI = 3'h1,
      SEL_RANGEQ = 3'h2,
      SEL_STATUS = 3'h3,
      SEL_NONE   = 3'h4
   } cpms_sel_t;

endpackage

// >>> hw/cpms_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous pins.
`timescale 1ns/1ps
module cpms_sync
#(
   parameter int unsigned WIDTH = 8
)
(
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         meta_reg <= '0;
         q_o      <= '0;
      end
      else
      begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end

endmodule

// >>> hw/cpms_top.sv
// Control pin and mode select logic with an AXI4-Lite register port.
`timescale 1ns/1ps
module cpms_top
#(
   parameter int unsigned POR_SHORT_CYC = cpms_pkg::POR_SHORT_CYC_DEF,
   parameter int unsigned POR_LONG_CYC  = cpms_pkg::POR_LONG_CYC_DEF,
   parameter int unsigned TUNE_RUN_CYC  = cpms_pkg::TUNE_RUN_CYC_DEF
)
(
   input  wire logic                            clk_i,
   input  wire logic                            rstn_i,
   input  wire logic [cpms_pkg::AXI_AW-1:0]     s_axi_awaddr_i,
   input  wire logic                            s_axi_awvalid_i,
   output logic                                 s_axi_awready_o,
   input  wire logic [31:0]                     s_axi_wdata_i,
   input  wire logic [3:0]                      s_axi_wstrb_i,
   input  wire logic                            s_axi_wvalid_i,
   output logic                                 s_axi_wready_o,
   output logic [1:0]                           s_axi_bresp_o,
   output logic                                 s_axi_bvalid_o,
   input  wire logic                            s_axi_bready_i,
   input  wire logic [cpms_pkg::AXI_AW-1:0]     s_axi_araddr_i,
   input  wire logic                            s_axi_arvalid_i,
   output logic                                 s_axi_arready_o,
   output logic [31:0]                          s_axi_rdata_o,
   output logic [1:0]                           s_axi_rresp_o,
   output logic                                 s_axi_rvalid_o,
   input  wire logic                            s_axi_rready_i,
   input  wire logic                            self_tune_request_i,
   input  wire logic                            power_on_tune_delay_sel_i,
   input  wire logic                            output_phase_select_i,
   input  wire logic                            interleaved_sampling_select_i,
   input  wire logic                            extended_ctrl_enable_n_i,
   input  wire logic                            input_range_select_i,
   input  wire logic                            nondemux_select_i,
   input  wire logic                            serial_select_n_i,
   output logic                                 tune_in_progress_o,
   output logic                                 extended_control_mode_o,
   output logic                                 phase_90_o,
   output logic                                 demux_1to2_o,
   output logic                                 interleave_o,
   output logic [cpms_pkg::RANGE_W-1:0]         range_i_o,
   output logic [cpms_pkg::RANGE_W-1:0]         range_q_o,
   output logic                                 serial_out_o,
   output logic                                 serial_out_oe_o
);
   import cpms_pkg::*;

   localparam logic [CNT_W-1:0] POR_SHORT_LAST = CNT_W'(POR_SHORT_CYC - 1);
   localparam logic [CNT_W-1:0] POR_LONG_LAST  = CNT_W'(POR_LONG_CYC - 1);
   localparam logic [CNT_W-1:0] RUN_LAST       = CNT_W'(TUNE_RUN_CYC - 1);

   logic [PIN_N-1:0]   pins_async;
   logic [PIN_N-1:0]   pins_s;
   logic               extended_control_mode;
   logic               tune_src;
   logic [31:0]        ctrl_reg;
   logic [RANGE_W-1:0] range_i_reg;
   logic [RANGE_W-1:0] range_q_reg;
   logic [AXI_AW-1:0]  awaddr_reg;
   logic [31:0]        wdata_reg;
   logic [3:0]         wstrb_reg;
   logic               write_fire;
   cpms_sel_t          wsel;
   logic [CNT_W-1:0]   lo_cnt_reg;
   logic [CNT_W-1:0]   hi_cnt_reg;
   logic               armed_reg;
   logic               tune_req_reg;
   cpms_state_t        st_reg;
   cpms_state_t        st_next;
   logic [CNT_W-1:0]   cnt_reg;

   function automatic cpms_sel_t decode(input logic [AXI_AW-1:0] addr);
      cpms_sel_t sel;
      sel = SEL_NONE;
      if (addr[1:0] == 2'h0)
      begin
         case (addr[AXI_AW-1:2])
            CTRL_IDX[AXI_AW-3:0]:    sel = SEL_CTRL;
            RANGE_I_IDX[AXI_AW-3:0]: sel = SEL_RANGEI;
            RANGE_Q_IDX[AXI_AW-3:0]: sel = SEL_RANGEQ;
            STATUS_IDX[AXI_AW-3:0]:  sel = SEL_STATUS;
            default:                 sel = SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Every pin is asynchronous to clk_i and passes two flip-flops first.
   always_comb
   begin
      pins_async            = '0;
      pins_async[PIN_TUNE]  = self_tune_request_i;
      pins_async[PIN_DLY]   = power_on_tune_delay_sel_i;
      pins_async[PIN_PHASE] = output_phase_select_i;
      pins_async[PIN_ILV]   = interleaved_sampling_select_i;
      // The enable is stored inverted so that the reset value means pins.
      pins_async[PIN_ECE_N] = !extended_ctrl_enable_n_i;
      pins_async[PIN_RANGE] = input_range_select_i;
      pins_async[PIN_NDM]   = nondemux_select_i;
      pins_async[PIN_SCS_N] = serial_select_n_i;
   end

   cpms_sync
   #(
      .WIDTH (PIN_N)
   )
   u_sync
   (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .d_i    (pins_async),
      .q_o    (pins_s)
   );

   assign extended_control_mode        = pins_s[PIN_ECE_N];
   assign tune_src   = pins_s[PIN_TUNE] | (extended_control_mode & ctrl_reg[TUNE_BIT]);
   assign write_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
   assign wsel       = decode(awaddr_reg);

   // Write channel: address and data are held until both are present.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s_axi_awready_o <= 1'h1;
         s_axi_wready_o  <= 1'h1;
         s_axi_bvalid_o  <= 1'h0;
         s_axi_bresp_o   <= RESP_OKAY;
         awaddr_reg      <= '0;
         wdata_reg       <= '0;
         wstrb_reg       <= '0;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            s_axi_awready_o <= 1'h0;
            awaddr_reg      <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            s_axi_wready_o <= 1'h0;
            wdata_reg      <= s_axi_wdata_i;
            wstrb_reg      <= s_axi_wstrb_i;
         end
         if (write_fire)
         begin
            s_axi_bvalid_o <= 1'h1;
            s_axi_bresp_o  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (s_axi_bvalid_o && s_axi_bready_i)
         begin
            s_axi_bvalid_o  <= 1'h0;
            s_axi_awready_o <= 1'h1;
            s_axi_wready_o  <= 1'h1;
         end
      end
   end

   // Registers stay at their defaults while extended control is off.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ctrl_reg    <= CTRL_RST;
         range_i_reg <= RANGE_RST;
         range_q_reg <= RANGE_RST;
      end
      else if (!extended_control_mode)
      begin
         ctrl_reg    <= CTRL_RST;
         range_i_reg <= RANGE_RST;
         range_q_reg <= RANGE_RST;
      end
      else if (write_fire)
      begin
         case (wsel)
            SEL_CTRL:
            begin
               ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & CTRL_WMASK;
            end
            SEL_RANGEI:
            begin
               range_i_reg <= wstrb_reg[0] ? wdata_reg[RANGE_W-1:0]
                                           : range_i_reg;
            end
            SEL_RANGEQ:
            begin
               range_q_reg <= wstrb_reg[0] ? wdata_reg[RANGE_W-1:0]
                                           : range_q_reg;
            end
            default:
            begin
               ctrl_reg <= ctrl_reg;
            end
         endcase
      end
   end

   // Read channel: data follow one cycle after the address is taken.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s_axi_arready_o <= 1'h1;
         s_axi_rvalid_o  <= 1'h0;
         s_axi_rdata_o   <= '0;
         s_axi_rresp_o   <= RESP_OKAY;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         s_axi_arready_o <= 1'h0;
         s_axi_rvalid_o  <= 1'h1;
         s_axi_rresp_o   <= RESP_OKAY;
         s_axi_rdata_o   <= '0;
         case (decode(s_axi_araddr_i))
            SEL_CTRL:   s_axi_rdata_o <= ctrl_reg;
            SEL_RANGEI: s_axi_rdata_o[RANGE_W-1:0] <= range_i_reg;
            SEL_RANGEQ: s_axi_rdata_o[RANGE_W-1:0] <= range_q_reg;
            SEL_STATUS:
            begin
               s_axi_rdata_o[ST_TIP_POS] <= tune_in_progress_o;
               s_axi_rdata_o[ST_ECM_POS] <= extended_control_mode_o;
               s_axi_rdata_o[ST_PH_POS]  <= phase_90_o;
               s_axi_rdata_o[ST_DMX_POS] <= demux_1to2_o;
               s_axi_rdata_o[ST_ILV_POS] <= interleave_o;
               s_axi_rdata_o[ST_INH_POS] <= (st_reg == ST_INHIBIT);
               s_axi_rdata_o[ST_RI_POS +: RANGE_W] <= range_i_o;
               s_axi_rdata_o[ST_RQ_POS +: RANGE_W] <= range_q_o;
            end
            default:    s_axi_rresp_o <= RESP_SLVERR;
         endcase
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
      begin
         s_axi_rvalid_o  <= 1'h0;
         s_axi_arready_o <= 1'h1;
      end
   end

   // Request detector: a long enough low arms it, a long enough high fires.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         lo_cnt_reg   <= '0;
         hi_cnt_reg   <= '0;
         armed_reg    <= 1'h0;
         tune_req_reg <= 1'h0;
      end
      else
      begin
         tune_req_reg <= 1'h0;
         if (!tune_src)
         begin
            hi_cnt_reg <= '0;
            if (lo_cnt_reg == TUNE_LOW_LAST)
            begin
               armed_reg <= 1'h1;
            end
            else
            begin
               lo_cnt_reg <= lo_cnt_reg + 1'h1;
            end
         end
         else
         begin
            lo_cnt_reg <= '0;
            if (armed_reg)
            begin
               if (hi_cnt_reg == TUNE_HIGH_LAST)
               begin
                  tune_req_reg <= 1'h1;
                  armed_reg    <= 1'h0;
                  hi_cnt_reg   <= '0;
               end
               else
               begin
                  hi_cnt_reg <= hi_cnt_reg + 1'h1;
               end
            end
         end
      end
   end

   always_comb
   begin
      st_next = st_reg;
      case (st_reg)
         ST_START:
         begin
            if (cnt_reg == STARTUP_LAST)
            begin
               st_next = pins_s[PIN_TUNE] ? ST_INHIBIT : ST_POR_WAIT;
            end
         end
         ST_POR_WAIT:
         begin
            if (tune_req_reg || cnt_reg == '0)
            begin
               st_next = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (cnt_reg == '0)
            begin
               st_next = ST_READY;
            end
         end
         ST_READY, ST_INHIBIT:
         begin
            if (tune_req_reg)
            begin
               st_next = ST_RUN;
            end
         end
         default: st_next = ST_START;
      endcase
   end

   // Tuning sequencer with one shared wait counter.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         st_reg             <= ST_START;
         cnt_reg            <= '0;
         tune_in_progress_o <= 1'h0;
      end
      else
      begin
         st_reg             <= st_next;
         tune_in_progress_o <= (st_next == ST_RUN);
         if (st_next == ST_RUN && st_reg != ST_RUN)
         begin
            cnt_reg <= RUN_LAST;
         end
         else if (st_next == ST_POR_WAIT && st_reg == ST_START)
         begin
            cnt_reg <= pins_s[PIN_DLY] ? POR_LONG_LAST : POR_SHORT_LAST;
         end
         else if (st_reg == ST_START)
         begin
            cnt_reg <= cnt_reg + 1'h1;
         end
         else if (cnt_reg != '0)
         begin
            cnt_reg <= cnt_reg - 1'h1;
         end
      end
   end

   // Effective mode outputs; in extended control registers replace the phase, interleave and range pins.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         extended_control_mode_o <= 1'h0;
         phase_90_o              <= 1'h0;
         demux_1to2_o            <= 1'h0;
         interleave_o            <= 1'h0;
         range_i_o               <= RANGE_MIN;
         range_q_o               <= RANGE_MIN;
         serial_out_o            <= 1'h0;
         serial_out_oe_o         <= 1'h0;
      end
      else
      begin
         extended_control_mode_o <= extended_control_mode;
         phase_90_o <= !pins_s[PIN_NDM] &&
                       (extended_control_mode ? ctrl_reg[PHASE_BIT]
                            : pins_s[PIN_PHASE]);
         demux_1to2_o <= !pins_s[PIN_NDM];
         interleave_o <= extended_control_mode ? ctrl_reg[ILV_BIT]
                             : pins_s[PIN_ILV];
         if (extended_control_mode)
         begin
            range_i_o <= range_i_reg;
            range_q_o <= range_q_reg;
         end
         else
         begin
            range_i_o <= pins_s[PIN_RANGE] ? RANGE_MID : RANGE_MIN;
            range_q_o <= pins_s[PIN_RANGE] ? RANGE_MID : RANGE_MIN;
         end
         serial_out_o    <= 1'h0;
         serial_out_oe_o <= extended_control_mode && !pins_s[PIN_SCS_N];
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   sequence s_low_seen;
      !tune_src;
   endsequence

   sequence s_run_end;
      $fell(tune_in_progress_o);
   endsequence

   property p_tip_len;
      s_run_end |-> $past(cnt_reg) == '0 && $past(st_reg) == ST_RUN;
   endproperty
   a_tip_len: assert property (p_tip_len)
      else $error("Tuning ended before its run time.");

   property p_req_cause;
      tune_req_reg |-> $past(tune_src) && $past(armed_reg)
                       && $past(hi_cnt_reg) == TUNE_HIGH_LAST;
   endproperty
   a_req_cause: assert property (p_req_cause)
      else $error("Tuning request without a full low then high.");

   property p_low_blocks;
      s_low_seen |=> !tune_req_reg;
   endproperty
   a_low_blocks: assert property (p_low_blocks)
      else $error("Tuning request while a source was low.");

   property p_inhibit;
      (st_reg == ST_INHIBIT && !tune_req_reg) |=> !tune_in_progress_o;
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("Power-on tuning ran while withheld.");

   property p_por_delay;
      (st_reg == ST_START && st_next == ST_POR_WAIT) |=>
         cnt_reg == ($past(pins_s[PIN_DLY]) ? POR_LONG_LAST : POR_SHORT_LAST);
   endproperty
   a_por_delay: assert property (p_por_delay)
      else $error("Power-on wait does not match the delay select.");

   property p_phase_demux;
      pins_s[PIN_NDM] |=> !phase_90_o && !demux_1to2_o;
   endproperty
   a_phase_demux: assert property (p_phase_demux)
      else $error("Phase applied outside 1:2 mode.");

   property p_phase_reg;
      (extended_control_mode && !pins_s[PIN_NDM]) |=> phase_90_o == $past(ctrl_reg[PHASE_BIT]);
   endproperty
   a_phase_reg: assert property (p_phase_reg)
      else $error("Phase not taken from the control register.");

   property p_ilv;
      1'h1 |=> interleave_o == ($past(extended_control_mode) ? $past(ctrl_reg[ILV_BIT])
                                           : $past(pins_s[PIN_ILV]));
   endproperty
   a_ilv: assert property (p_ilv)
      else $error("Interleave source is wrong.");

   property p_defaults;
      !extended_control_mode |=> ctrl_reg == CTRL_RST && range_i_reg == RANGE_RST;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("Registers left their defaults without extended control.");

   property p_range_pin;
      !extended_control_mode |=> range_i_o == range_q_o
               && (range_i_o == RANGE_MID) == $past(pins_s[PIN_RANGE]);
   endproperty
   a_range_pin: assert property (p_range_pin)
      else $error("Pin range not applied to both channels.");

   property p_serial_off;
      pins_s[PIN_SCS_N] |=> !serial_out_oe_o;
   endproperty
   a_serial_off: assert property (p_serial_off)
      else $error("Serial output driven while deselected.");

endmodule

// >>> tb/cpms_host.sv
// Host model that drives the tuning request pin.
`timescale 1ns/1ps
module cpms_host
(
   input  wire logic clk_i,
   output logic      tune_req_o
);
   initial tune_req_o = 1'b0;

   // Low, then high, each held past the least time plus the sync delay.
   task automatic pulse();
      tune_req_o <= 1'b0;
      repeat (30) @(posedge clk_i);
      tune_req_o <= 1'b1;
      repeat (30) @(posedge clk_i);
   endtask

   // Leaves the request pin low, as before a plain power-on.
   task automatic hold_low();
      tune_req_o <= 1'b0;
   endtask
endmodule

// >>> tb/cpms_top_tb.sv
// Self-checking bench for the control pin and mode select block.
`timescale 1ns/1ps
module cpms_top_tb;
   import cpms_pkg::*;
   localparam int PS = 40, PL = 80, RUN = 20;
   logic clk_i, rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
   logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
   logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, tune_in_progress_o;
   logic extended_control_mode_o, phase_90_o, demux_1to2_o, interleave_o;
   logic serial_out_o, serial_out_oe_o, self_tune_request_i;
   logic power_on_tune_delay_sel_i, output_phase_select_i, nondemux_select_i;
   logic interleaved_sampling_select_i, extended_ctrl_enable_n_i;
   logic input_range_select_i, serial_select_n_i;
   logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o, seed, d, v;
   logic [3:0]  s_axi_wstrb_i, range_i_o, range_q_o, ri, rq;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
   int          checks = 0, fail_count = 0, cyc = 0, w, n;

   cpms_top #(.POR_SHORT_CYC(PS), .POR_LONG_CYC(PL), .TUNE_RUN_CYC(RUN))
      i_dut (.*);
   cpms_host i_host (.clk_i(clk_i), .tune_req_o(self_tune_request_i));

   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         summarize();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   function automatic logic [11:0] expm(input logic e);
      logic [3:0] pr;
      pr = input_range_select_i ? RANGE_MID : RANGE_MIN;
      return {e, (e ? d[PHASE_BIT] : output_phase_select_i)
         & ~nondemux_select_i, ~nondemux_select_i,
         e ? d[ILV_BIT] : interleaved_sampling_select_i,
         e ? ri : pr, e ? rq : pr};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, s);
      checks++;
      if (s !== e)
      begin
         $display("BAD %s exp %h got %h", nm, e, s);
         fail_count++;
      end
   endtask

   task automatic summarize();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dd);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= dd;
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
      fork
         begin
            do @(posedge clk_i); while (!s_axi_awready_o);
            s_axi_awvalid_i <= 1'b0;
         end
         begin
            do @(posedge clk_i); while (!s_axi_wready_o);
            s_axi_wvalid_i <= 1'b0;
         end
      join
      do @(posedge clk_i); while (!s_axi_bvalid_o);
      r = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a);
      s_axi_araddr_i <= a;
      {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
      do @(posedge clk_i); while (!s_axi_arready_o);
      s_axi_arvalid_i <= 1'b0;
      do @(posedge clk_i); while (!s_axi_rvalid_o);
      v = s_axi_rdata_o;
      r = s_axi_rresp_o;
      s_axi_rready_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic tune();
      w = 0;
      n = 0;
      while (!tune_in_progress_o && w < 300)
      begin
         @(posedge clk_i);
         w++;
      end
      while (tune_in_progress_o)
      begin
         @(posedge clk_i);
         n++;
      end
   endtask

   task automatic modes(input logic e);
      repeat (6)
      begin
         seed = xs(seed);
         {output_phase_select_i, interleaved_sampling_select_i,
            input_range_select_i, nondemux_select_i,
            serial_select_n_i} <= seed[4:0];
         repeat (5) @(posedge clk_i);
         chk("mode", expm(e), {extended_control_mode_o, phase_90_o,
            demux_1to2_o, interleave_o, range_i_o, range_q_o});
         chk("oe", e & ~serial_select_n_i, serial_out_oe_o);
      end
   endtask

   initial
   begin
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
      {s_axi_arvalid_i, s_axi_rready_i, serial_select_n_i} = 3'h1;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, d} = 80'h0;
      {output_phase_select_i, interleaved_sampling_select_i} = 2'h0;
      {input_range_select_i, nondemux_select_i} = 2'h0;
      {power_on_tune_delay_sel_i, extended_ctrl_enable_n_i} = 2'h1;
      s_axi_wstrb_i = 4'hF;
      seed = 32'hD6FD;
      rstn_i = 1'b0;
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      tune();
      chk("por wait", 1, w >= PS && w < PL);
      chk("tune len", RUN, n);
      modes(0);
      wr(8'h00, 32'h0000C080);
      rd(8'h00);
      chk("ctrl off", CTRL_RST, v);
      extended_ctrl_enable_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      seed = xs(seed);
      {rq, ri} = seed[23:16];
      d = seed & 32'h00007FFF;
      wr(8'(CTRL_IDX * 4), d);
      wr(8'(RANGE_I_IDX * 4), {28'h0, ri});
      wr(8'(RANGE_Q_IDX * 4), {28'h0, rq});
      wr(8'h01, 32'hFFFFFFFF);
      chk("misaligned", RESP_SLVERR, r);
      rd(8'h00);
      chk("ctrl", d & CTRL_WMASK, v);
      rd(8'h44);
      chk("unmapped", RESP_SLVERR, r);
      modes(1);
      wr(8'h00, d | 32'h00008000);
      tune();
      chk("reg tune", RUN, n);
      wr(8'h00, d);
      fork
         i_host.pulse();
         tune();
      join
      chk("pin tune", RUN, n);
      extended_ctrl_enable_n_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rd(8'h0C);
      chk("range dflt", RANGE_RST, v);
      modes(0);
      rstn_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      tune();
      chk("withheld", 300, w);
      fork
         i_host.pulse();
         tune();
      join
      chk("late tune", RUN, n);
      i_host.hold_low();
      power_on_tune_delay_sel_i <= 1'b1;
      rstn_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      tune();
      chk("por long", 1, w >= PL && w < 300);
      chk("long len", RUN, n);
      summarize();
   end
endmodule
